/* uart_lin_pkg.sv */
// shared constants and types for the lin-capable serial unit
package uart_lin_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CLKSEL = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_DIV = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_TXBUF = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_RXBUF = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_ERRST = 8'h18;
  // serial_mode_reg fields
  localparam int MODE_POWER = 7;
  localparam int MODE_TXE = 6;
  localparam int MODE_RXE = 5;
  localparam int MODE_MERGE = 0;
  // serial_ctrl_reg fields
  localparam int CTRL_SBRF = 7;
  localparam int CTRL_SBRT = 6;
  localparam int CTRL_SBTT = 5;
  localparam int CTRL_BLEN_HI = 4;
  localparam int CTRL_BLEN_LO = 2;
  // rx_err_status_reg fields
  localparam int ERR_OVR = 0;
  localparam int ERR_FE = 1;
  localparam int ERR_PE = 2;
  localparam logic [7:0] RXBUF_RST = 8'hFF;
  localparam logic [7:0] DIV_RST = 8'hFF;
  localparam logic [3:0] PRESCALE_MAX = 4'hB;
  localparam logic [4:0] DATA_BITS = 5'h08;
  localparam logic [4:0] BRK_TX_BASE = 5'h0D;
  localparam logic [4:0] BRK_RX_MIN = 5'h0B;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_BRK} tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_CHK, RX_DATA, RX_STOP, RX_BRK} rx_st_t;
endpackage : uart_lin_pkg

/* rx_noise_filter.sv */
// two-sample agreement filter on the serial input
`timescale 1ns/1ps
module rx_noise_filter (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic din,
  output logic dout
);
  import uart_lin_pkg::*;
  typedef struct packed {
    logic s0;
    logic s1;
    logic lvl;
  } flt_t;
  flt_t q;
  flt_t d;
  always_comb begin
    d = q;
    if (tick) begin
      d.s0 = din;
      d.s1 = q.s0;
      if (q.s0 == q.s1) begin
        d.lvl = q.s1;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '{s0: 1'b1, s1: 1'b1, lvl: 1'b1};
    end else begin
      q <= d;
    end
  end
  assign dout = q.lvl;
endmodule : rx_noise_filter

/* baud_counter.sv */
// 8-bit divisor counter, pulses every k base ticks
`timescale 1ns/1ps
module baud_counter (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clr,
  input wire logic tick,
  input wire logic [7:0] k,
  output logic match
);
  import uart_lin_pkg::*;
  typedef struct packed {
    logic [7:0] cnt;
  } cnt_t;
  cnt_t q;
  cnt_t d;
  logic hit;
  // k below the documented minimum still divides; software keeps k in range
  assign hit = tick && (q.cnt == k - 8'h01);
  always_comb begin
    d = q;
    if (clr) begin
      d.cnt = '0;
    end else if (hit) begin
      d.cnt = '0;
    end else if (tick) begin
      d.cnt = q.cnt + 8'h01;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign match = hit && !clr;
endmodule : baud_counter

/* uart_lin_break_baud_gen.sv */
// lin break, noise filter and baud generation for the serial unit
// Notes on behaviour
// - merge set: errors go on rx done
// - input passes only on two agreeing samples
// - receive path lags pin by three ticks
// - power off drives serial output high
// - transmit enable then trigger starts break
// - break low for 13 to 20 bits
// - break end: tx done, trigger auto-clears
// - idle after break until data/trigger
// - break receive detects start bit normally
// - long break: rx done, clear flag, trigger
// - no error flags during break receive
// - break receive never loads receive buffer
// - short break: silent, flags kept, rearm
// - base clock only while power set
// - separate 8-bit tx and rx counters
// - tx counter cleared unless power, enable
// - tx counter cleared at each frame start
// - rx counter runs start to frame end
// - baud is base clock over 2k
// - merge bit 0; otherwise separate lines
// - falling edge, k ticks, low confirms start
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module uart_lin_break_baud_gen (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [uart_lin_pkg::ADDR_W-1:0] paddr,
  input wire logic [uart_lin_pkg::DATA_W-1:0] pwdata,
  output logic [uart_lin_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic tx_done_irq,
  output logic rx_done_irq,
  output logic rx_err_irq
);
  import uart_lin_pkg::*;

  typedef struct packed {
    logic power;
    logic txe;
    logic rxe;
    logic merge;
    logic [2:0] brk_len;
    logic sbtt;
    logic sbrt;
    logic sbrf;
    logic [3:0] prescale_sel;
    logic [7:0] k;
    logic [7:0] txb;
    logic txb_full;
    logic [7:0] rxb;
    logic rxb_full;
    logic ovr;
    logic fe;
    logic pe;
    logic [11:0] pre;
    tx_st_t tx_st;
    logic tx_half;
    logic [4:0] tx_bits;
    logic [7:0] tx_sh;
    logic tx_line;
    rx_st_t rx_st;
    logic rx_half;
    logic [4:0] rx_bits;
    logic [7:0] rx_sh;
    logic rx_prev;
    logic tx_irq;
    logic rx_irq;
    logic err_irq;
    logic ready;
    logic slverr;
    logic [DATA_W-1:0] rdata;
  } state_t;

  state_t q;
  state_t d;

  function automatic logic [11:0] pre_mask(input logic [3:0] n);
    logic [3:0] m;
    m = (n > PRESCALE_MAX) ? PRESCALE_MAX : n;
    pre_mask = 12'((13'h0001 << m) - 13'h0001);
  endfunction : pre_mask

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a == OFF_MODE) || (a == OFF_CTRL) || (a == OFF_CLKSEL) || (a == OFF_DIV) ||
      (a == OFF_TXBUF) || (a == OFF_RXBUF) || (a == OFF_ERRST);
  endfunction : reg_hit

  logic tick;
  logic rx_lvl;
  logic tx_match;
  logic rx_match;
  logic tx_run;
  logic rx_run;
  logic tx_clr;
  logic rx_clr;
  logic tx_go;
  logic setup;
  logic access;
  logic wr;
  logic rd_rxb;
  logic rd_err;
  logic tx_bit_end;
  logic rx_sample;
  logic rx_err;

  // base clock exists only with power on; fixed low otherwise
  assign tick = q.power && ((q.pre & pre_mask(q.prescale_sel)) == pre_mask(q.prescale_sel));
  assign tx_run = q.power && q.txe;
  assign rx_run = q.power && q.rxe;
  assign tx_go = tx_run && (q.tx_st == TX_IDLE) && (q.sbtt || q.txb_full);
  assign tx_clr = !tx_run || tx_go || (q.tx_st == TX_STOP && tx_bit_end && q.txb_full);
  // rx counter halts between frames so each start realigns timing
  assign rx_clr = !rx_run || (q.rx_st == RX_IDLE);
  assign tx_bit_end = tx_match && q.tx_half;
  assign rx_sample = rx_match && q.rx_half;
  assign setup = psel && !penable;
  assign access = psel && penable && q.ready;
  assign wr = access && pwrite;
  // read-clear at the edge that latches read data, so no set slips between latch and clear
  assign rd_rxb = setup && !pwrite && (paddr == OFF_RXBUF);
  assign rd_err = setup && !pwrite && (paddr == OFF_ERRST);

  rx_noise_filter u_filter (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tick(tick),
    .din(serial_in_pin),
    .dout(rx_lvl)
  );

  baud_counter u_tx_cnt (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clr(tx_clr),
    .tick(tick),
    .k(q.k),
    .match(tx_match)
  );

  baud_counter u_rx_cnt (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clr(rx_clr),
    .tick(tick),
    .k(q.k),
    .match(rx_match)
  );

  always_comb begin
    d = q;
    d.tx_irq = 1'b0;
    d.rx_irq = 1'b0;
    d.err_irq = 1'b0;
    rx_err = 1'b0;
    d.pre = q.power ? q.pre + 12'h001 : '0;

    // transmit side
    if (tx_match) begin
      d.tx_half = !q.tx_half;
    end
    case (q.tx_st)
      TX_IDLE: begin
        d.tx_half = 1'b0;
        if (tx_go && q.sbtt) begin
          d.tx_st = TX_BRK;
          d.tx_bits = '0;
        end else if (tx_go) begin
          d.tx_st = TX_START;
          d.tx_sh = q.txb;
          d.txb_full = 1'b0;
        end
      end
      TX_START: begin
        if (tx_bit_end) begin
          d.tx_st = TX_DATA;
          d.tx_bits = '0;
        end
      end
      TX_DATA: begin
        if (tx_bit_end) begin
          d.tx_sh = {1'b1, q.tx_sh[7:1]};
          d.tx_bits = q.tx_bits + 5'h01;
          if (q.tx_bits == DATA_BITS - 5'h01) begin
            d.tx_st = TX_STOP;
          end
        end
      end
      TX_STOP: begin
        if (tx_bit_end) begin
          d.tx_irq = 1'b1;
          d.tx_half = 1'b0;
          if (q.txb_full) begin
            d.tx_st = TX_START;
            d.tx_sh = q.txb;
            d.txb_full = 1'b0;
          end else begin
            d.tx_st = TX_IDLE;
          end
        end
      end
      TX_BRK: begin
        if (tx_bit_end) begin
          d.tx_bits = q.tx_bits + 5'h01;
          if (q.tx_bits == BRK_TX_BASE + 5'(q.brk_len) - 5'h01) begin
            d.tx_irq = 1'b1;
            d.sbtt = 1'b0;
            d.tx_st = TX_IDLE;
          end
        end
      end
      default: d.tx_st = TX_IDLE;
    endcase
    if (!tx_run) begin
      d.tx_st = TX_IDLE;
      d.tx_half = 1'b0;
    end
    case (d.tx_st)
      TX_START: d.tx_line = 1'b0;
      TX_DATA: d.tx_line = d.tx_sh[0];
      TX_BRK: d.tx_line = 1'b0;
      default: d.tx_line = 1'b1;
    endcase

    // receive side
    d.rx_prev = rx_lvl;
    if (rx_match) begin
      d.rx_half = !q.rx_half;
    end
    case (q.rx_st)
      RX_IDLE: begin
        d.rx_half = 1'b0;
        if (q.rx_prev && !rx_lvl) begin
          d.rx_st = RX_CHK;
        end
      end
      RX_CHK: begin
        if (rx_match) begin
          d.rx_half = 1'b0;
          d.rx_bits = q.sbrt ? 5'h01 : 5'h00;
          if (rx_lvl) begin
            d.rx_st = RX_IDLE;
          end else if (q.sbrt) begin
            d.rx_st = RX_BRK;
          end else begin
            d.rx_st = RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (rx_sample) begin
          d.rx_sh = {rx_lvl, q.rx_sh[7:1]};
          d.rx_bits = q.rx_bits + 5'h01;
          if (q.rx_bits == DATA_BITS - 5'h01) begin
            d.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_sample) begin
          d.rx_st = RX_IDLE;
          rx_err = !rx_lvl || q.rxb_full;
          d.fe = !rx_lvl;
          d.ovr = q.rxb_full;
          if (!q.rxb_full) begin
            d.rxb = q.rx_sh;
            d.rxb_full = 1'b1;
          end
          d.rx_irq = !rx_err || q.merge;
          d.err_irq = rx_err && !q.merge;
        end
      end
      RX_BRK: begin
        if (rx_sample) begin
          // overflow guard: a stuck-low line just saturates the width
          if (!rx_lvl) begin
            d.rx_bits = (q.rx_bits == 5'h1F) ? q.rx_bits : q.rx_bits + 5'h01;
          end else begin
            d.rx_st = RX_IDLE;
            if (q.rx_bits >= BRK_RX_MIN) begin
              d.rx_irq = 1'b1;
              d.sbrf = 1'b0;
              d.sbrt = 1'b0;
            end
            // short break: flags stay, rearm quietly
          end
        end
      end
      default: d.rx_st = RX_IDLE;
    endcase
    if (!rx_run) begin
      d.rx_st = RX_IDLE;
      d.rx_half = 1'b0;
    end
    // break receive never touches error flags or the buffer
    // error flags: hardware set wins over read-clear
    if (rd_err) begin
      d.ovr = (q.rx_st == RX_STOP) && rx_sample && q.rxb_full;
      d.fe = (q.rx_st == RX_STOP) && rx_sample && !rx_lvl;
      d.pe = 1'b0;
    end
    if (rd_rxb && !(q.rx_st == RX_STOP && rx_sample && !q.rxb_full)) begin
      d.rxb_full = 1'b0;
    end

    // apb slave, zero wait states
    d.ready = setup;
    if (setup) begin
      d.slverr = !reg_hit(paddr);
      d.rdata = '0;
      case (paddr)
        OFF_MODE: begin
          d.rdata[MODE_POWER] = q.power;
          d.rdata[MODE_TXE] = q.txe;
          d.rdata[MODE_RXE] = q.rxe;
          d.rdata[MODE_MERGE] = q.merge;
        end
        OFF_CTRL: begin
          d.rdata[CTRL_SBRF] = q.sbrf;
          d.rdata[CTRL_SBRT] = q.sbrt;
          d.rdata[CTRL_SBTT] = q.sbtt;
          d.rdata[CTRL_BLEN_HI:CTRL_BLEN_LO] = q.brk_len;
        end
        OFF_CLKSEL: d.rdata[3:0] = q.prescale_sel;
        OFF_DIV: d.rdata[7:0] = q.k;
        OFF_RXBUF: d.rdata[7:0] = q.rxb;
        OFF_ERRST: begin
          d.rdata[ERR_OVR] = q.ovr;
          d.rdata[ERR_FE] = q.fe;
          d.rdata[ERR_PE] = q.pe;
        end
        default: d.rdata = '0;
      endcase
    end else if (access) begin
      d.slverr = 1'b0;
    end
    if (wr) begin
      case (paddr)
        OFF_MODE: begin
          d.power = pwdata[MODE_POWER];
          d.txe = pwdata[MODE_TXE];
          d.rxe = pwdata[MODE_RXE];
          d.merge = pwdata[MODE_MERGE];
        end
        OFF_CTRL: begin
          d.brk_len = pwdata[CTRL_BLEN_HI:CTRL_BLEN_LO];
          if (pwdata[CTRL_SBTT]) begin
            d.sbtt = 1'b1;
          end
          if (pwdata[CTRL_SBRT]) begin
            d.sbrt = 1'b1;
            d.sbrf = 1'b1;
          end
        end
        OFF_CLKSEL: d.prescale_sel = pwdata[3:0];
        OFF_DIV: d.k = pwdata[7:0];
        OFF_TXBUF: begin
          d.txb = pwdata[7:0];
          d.txb_full = 1'b1;
        end
        default: d.k = d.k;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
      q.k <= DIV_RST;
      q.rxb <= RXBUF_RST;
      q.tx_st <= TX_IDLE;
      q.rx_st <= RX_IDLE;
      q.tx_line <= 1'b1;
      q.rx_prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.slverr;
  assign serial_out_pin = q.tx_line;
  assign tx_done_irq = q.tx_irq;
  assign rx_done_irq = q.rx_irq;
  assign rx_err_irq = q.err_irq;
endmodule : uart_lin_break_baud_gen

/* uart_lin_asserts.sv */
// checker for the lin break and baud unit ports
`timescale 1ns/1ps
module uart_lin_asserts (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [uart_lin_pkg::ADDR_W-1:0] paddr,
  input wire logic [uart_lin_pkg::DATA_W-1:0] pwdata,
  input wire logic [uart_lin_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic tx_done_irq,
  input wire logic rx_done_irq,
  input wire logic rx_err_irq
);
  import uart_lin_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  AST_SETUP_READY: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_READY_ONCE: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error outside access");
  AST_ERR_READ_ZERO: assert property (pslverr && !pwrite |-> prdata == '0)
    else $error("refused read not zero");
  AST_IRQ_SPLIT: assert property (!(rx_done_irq && rx_err_irq))
    else $error("done and error together");
  AST_TXDONE_PULSE: assert property (tx_done_irq |=> !tx_done_irq)
    else $error("tx done too long");
  AST_RXDONE_PULSE: assert property (rx_done_irq |=> !rx_done_irq)
    else $error("rx done too long");
  // k of 8 or more keeps any low bit at 16 clocks at least
  AST_LOW_MIN: assert property ($fell(serial_out_pin) |=> !serial_out_pin [*8])
    else $error("low level too short");
  AST_TXDONE_HIGH: assert property (tx_done_irq |-> ##[0:2] serial_out_pin)
    else $error("line not high after tx");
endmodule : uart_lin_asserts
bind uart_lin_break_baud_gen uart_lin_asserts chk_i (.mclk(mclk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in_pin(serial_in_pin),
  .serial_out_pin(serial_out_pin), .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq),
  .rx_err_irq(rx_err_irq));

/* serial_peer.sv */
// remote serial node: sends frames and breaks, decodes our output
`timescale 1ns/1ps
module serial_peer #(
  parameter int BIT = 16
) (
  input wire logic mclk,
  input wire logic line_in,
  output logic line_out
);
  logic [7:0] got;
  int got_cnt;
  initial begin
    line_out = 1'b1;
    got = 8'h00;
    got_cnt = 0;
  end
  task automatic hold(input logic v, input int n);
    line_out <= v;
    repeat (n) @(posedge mclk);
  endtask : hold
  // start low, lsb first, chosen stop level, then idle high
  task automatic send(input logic [7:0] b, input logic stp);
    @(posedge mclk);
    hold(1'b0, BIT);
    for (int i = 0; i < 8; i++) begin
      hold(b[i], BIT);
    end
    hold(stp, BIT);
    hold(1'b1, BIT);
  endtask : send
  task automatic send_low(input int n);
    @(posedge mclk);
    hold(1'b0, n * BIT);
    hold(1'b1, 2 * BIT);
  endtask : send_low
  // sample mid bit; a break decodes as zero, then wait for idle
  always begin
    @(posedge mclk);
    if (line_in === 1'b0) begin
      repeat (BIT / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge mclk);
        got[i] = line_in;
      end
      got_cnt++;
      while (line_in !== 1'b1) @(posedge mclk);
    end
  end
endmodule : serial_peer

/* tb.sv */
// testbench: apb register sequences against the serial peer
`timescale 1ns/1ps
module tb;
  import uart_lin_pkg::*;
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic serial_in_pin, serial_out_pin, tx_done_irq, rx_done_irq, rx_err_irq;
  int n_errors = 0, comparisons = 0, n_tx = 0, n_rx = 0, n_re = 0, cnt, e, k;
  uart_lin_break_baud_gen uut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq), .rx_err_irq(rx_err_irq));
  serial_peer #(.BIT(16)) peer (.mclk(mclk), .line_in(serial_out_pin), .line_out(serial_in_pin));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (tx_done_irq === 1'b1) n_tx <= n_tx + 1;
    if (rx_done_irq === 1'b1) n_rx <= n_rx + 1;
    if (rx_err_irq === 1'b1) n_re <= n_re + 1;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #500000;
    n_errors++;
    end_of_test();
  end
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    apb(1'b0, OFF_DIV, 0);
    chk("div", rd, {24'h0, DIV_RST});
    apb(1'b0, OFF_RXBUF, 0);
    chk("rxbuf", rd, {24'h0, RXBUF_RST});
    apb(1'b0, 8'h1C, 0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    apb(1'b1, OFF_CLKSEL, 0);
    apb(1'b1, OFF_DIV, 8);
    apb(1'b1, OFF_MODE, 32'hE0);
    chk("idle out", serial_out_pin, 1);
    $display("done reset");
    // break lengths: every code, bit time 2k clocks with n = 0
    // last pass: code 0 with base clock halved, bit time doubles
    for (int c = 0; c < 9; c++) begin
      if (c == 8) apb(1'b1, OFF_CLKSEL, 1);
      apb(1'b1, OFF_CTRL, 32'h20 | ((c & 7) << 2));
      cnt = 0;
      while (serial_out_pin === 1'b1 && cnt < 100) begin
        @(posedge mclk);
        cnt++;
      end
      cnt = 0;
      while (serial_out_pin === 1'b0) begin
        @(posedge mclk);
        cnt++;
      end
      e = (c == 8) ? 13 * 32 : (13 + c) * 16;
      chk("brk len", (cnt >= e - 2 && cnt <= e + 2), 1);
      repeat (3) @(posedge mclk);
      chk("tx done", n_tx, c + 1);
      apb(1'b0, OFF_CTRL, 0);
      chk("trig clr", rd[CTRL_SBTT], 0);
    end
    apb(1'b1, OFF_CLKSEL, 0);
    e = 0;
    repeat (200) begin
      @(posedge mclk);
      if (serial_out_pin !== 1'b1) e++;
    end
    chk("idle", e, 0);
    $display("done break tx");
    apb(1'b1, OFF_CTRL, 32'h40);
    peer.send_low(9);
    repeat (20) @(posedge mclk);
    chk("short brk", n_rx, 0);
    apb(1'b0, OFF_CTRL, 0);
    chk("flags kept", rd[7:6], 2'b11);
    peer.send_low(12);
    repeat (20) @(posedge mclk);
    chk("long brk", n_rx, 1);
    apb(1'b0, OFF_CTRL, 0);
    chk("flags clr", rd[7:6], 2'b00);
    apb(1'b0, OFF_RXBUF, 0);
    chk("brk buf", rd, {24'h0, RXBUF_RST});
    apb(1'b0, OFF_ERRST, 0);
    chk("brk err", rd, 0);
    $display("done break rx");
    k = peer.got_cnt;
    apb(1'b1, OFF_TXBUF, 32'h3C);
    while (peer.got_cnt != k + 1) @(posedge mclk);
    repeat (40) @(posedge mclk);
    chk("tx byte", peer.got, 8'h3C);
    chk("tx irq", n_tx, 10);
    peer.send(8'hA5, 1'b1);
    repeat (20) @(posedge mclk);
    chk("rx irq", n_rx, 2);
    apb(1'b0, OFF_RXBUF, 0);
    chk("rx byte", rd, 32'hA5);
    // framing error, separate lines then merged
    peer.send(8'h5A, 1'b0);
    repeat (20) @(posedge mclk);
    chk("err split rx", n_rx, 2);
    chk("err split err", n_re, 1);
    apb(1'b0, OFF_ERRST, 0);
    chk("fe flag", rd, 32'h2);
    apb(1'b0, OFF_RXBUF, 0);
    apb(1'b1, OFF_MODE, 32'hE1);
    peer.send(8'h5A, 1'b0);
    repeat (20) @(posedge mclk);
    chk("err merge rx", n_rx, 3);
    chk("err merge err", n_re, 1);
    $display("done frames");
    apb(1'b1, OFF_MODE, 0);
    repeat (5) @(posedge mclk);
    chk("off out", serial_out_pin, 1);
    $display("done power");
    end_of_test();
  end
endmodule : tb
